/* hw/otfs_top.sv */
`include "otfs_map.svh"

module otfs_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [99:0] function_signals,
  input wire logic safety_circuit_fault,
  output logic run_terminal_out,
  output logic relay_changeover_terminal,
  output logic safety_terminal_out,
  output logic second_safety_monitor_out,
  output logic irq
);

  // ************************************************************
  // Code checks and terminal level
  // ************************************************************
  function automatic logic base_listed(input logic [6:0] b);
    logic ok;
    ok = 1'b0;
    // One table for all three terminals; per-terminal exceptions come after
    case (b)
      7'h00, 7'h01, 7'h03, 7'h04, 7'h07, 7'h08, 7'h19, 7'h1a, 7'h2e, 7'h2f, 7'h40, 7'h46,
      7'h50, 7'h51, 7'h5a, 7'h5b, 7'h5d, 7'h5f, 7'h60, 7'h62, 7'h63: ok = 1'b1;
      default: ok = (b >= 7'h0b) && (b <= 7'h10);
    endcase
    return ok;
  endfunction : base_listed

  function automatic logic [6:0] code_base(input otfs_pkg::otfs_code_t c);
    otfs_pkg::otfs_code_t t;
    t = (c >= `OTFS_NEG_OFFSET) ? c - `OTFS_NEG_OFFSET : c;
    return t[6:0];
  endfunction : code_base

  function automatic logic code_ok(input logic [1:0] term, input otfs_pkg::otfs_code_t c);
    logic ok;
    ok = 1'b0;
    // Codes from 200 up, other than 9999, fall through as refused
    if (c == `OTFS_CODE_NONE) begin
      ok = (term != otfs_pkg::OTFS_TERM_SAFETY);
    end else if (c < (`OTFS_NEG_OFFSET * 16'h0002)) begin
      ok = base_listed(code_base(c));
      if (term == otfs_pkg::OTFS_TERM_RELAY && code_base(c) == `OTFS_CODE_RELAY_BAD) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : code_ok

  function automatic logic term_level(input otfs_pkg::otfs_code_t c, input logic [99:0] sig,
                                      input logic rem);
    logic lvl;
    lvl = 1'b0;
    // Base 96 hands the terminal to the remote word; 9999 parks it low
    if (c != `OTFS_CODE_NONE) begin
      lvl = (code_base(c) == `OTFS_CODE_REMOTE) ? rem : sig[code_base(c)];
      lvl = lvl ^ (c >= `OTFS_NEG_OFFSET);
    end
    return lvl;
  endfunction : term_level

  // ************************************************************
  // Register bus slave
  // ************************************************************
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;

  assign do_wr = aw_held && w_held && !s_axi_bvalid;
  assign next_aw_held = aw_held ? !do_wr : (s_axi_awvalid && s_axi_awready);
  assign next_w_held = w_held ? !do_wr : (s_axi_wvalid && s_axi_wready);
  assign next_bvalid = s_axi_bvalid ? !s_axi_bready : do_wr;
  assign next_rvalid = s_axi_rvalid ? !s_axi_rready : (s_axi_arvalid && s_axi_arready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      // Ready drops while a response waits, so one write at a time
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Holes past the last register answer SLVERR rather than aliasing
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_W'(`OTFS_OFF_LEVELS));
  endfunction : mapped

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= 2'h0;
    end else if (do_wr) begin
      s_axi_bresp <= mapped(aw_addr) ? 2'h0 : 2'h2;
    end
  end

  function automatic otfs_pkg::otfs_code_t merge16(input otfs_pkg::otfs_code_t old,
                                                   input logic [31:0] d, input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // ************************************************************
  // Configuration registers
  // ************************************************************
  otfs_pkg::otfs_code_t sel [3];
  otfs_pkg::otfs_code_t ext_disp;
  otfs_pkg::otfs_remote_t remote_word;
  otfs_pkg::otfs_status_t status;
  otfs_pkg::otfs_status_t mask;
  logic [2:0] sel_hit;
  logic [2:0] sel_refused;

  localparam otfs_pkg::otfs_code_t SEL_RST [3] = '{
    `OTFS_RST_RUN_SEL, `OTFS_RST_RELAY_SEL, `OTFS_RST_SAFETY_SEL};
  localparam logic [3:0] REM_BIT [3] = '{`OTFS_REM_RUN, `OTFS_REM_RELAY, `OTFS_REM_SAFETY};

  logic [2:0] term_q;
  logic [99:0] sig_all;

  // Code 81 follows the internal safety monitor, not the external vector
  always_comb begin
    sig_all = function_signals;
    sig_all[`OTFS_CODE_SECOND_SAFETY_MONITOR_OUT] = !safety_circuit_fault;
  end

  for (genvar i = 0; i < 3; i++) begin : g_term
    otfs_pkg::otfs_code_t wr_val;
    assign wr_val = merge16(sel[i], w_data, w_strb);
    assign sel_hit[i] = do_wr && (aw_addr == ADDR_W'(`OTFS_OFF_RUN_SEL + 8'(4 * i)));
    // Lock and bad codes both refuse; the old value is kept
    assign sel_refused[i] = sel_hit[i] &&
                            ((ext_disp != 16'h0000) || !code_ok(2'(i), wr_val));

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sel[i] <= SEL_RST[i];
      end else if (sel_hit[i] && !sel_refused[i]) begin
        sel[i] <= wr_val;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        term_q[i] <= 1'b0;
      end else begin
        term_q[i] <= term_level(sel[i], sig_all, remote_word[REM_BIT[i]]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_disp <= `OTFS_RST_EXT_DISP;
      remote_word <= `OTFS_RST_REMOTE;
      mask <= 2'h0;
    end else if (do_wr) begin
      // The display selection is never locked itself, or the lock could not be undone
      case (aw_addr)
        ADDR_W'(`OTFS_OFF_EXT_DISP): ext_disp <= merge16(ext_disp, w_data, w_strb);
        ADDR_W'(`OTFS_OFF_REMOTE): remote_word <= 12'(merge16(16'(remote_word), w_data, w_strb));
        ADDR_W'(`OTFS_OFF_MASK): mask <= w_strb[0] ? w_data[1:0] : mask;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  logic fault_q;
  otfs_pkg::otfs_status_t ev;
  otfs_pkg::otfs_status_t clr;

  assign ev[`OTFS_ST_REFUSED] = |sel_refused;
  // Edge based, so a fault that stays raised reports once
  assign ev[`OTFS_ST_SAFE_FAULT] = safety_circuit_fault && !fault_q;
  assign clr = (do_wr && aw_addr == ADDR_W'(`OTFS_OFF_STATUS) && w_strb[0]) ? w_data[1:0] : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
      status <= 2'h0;
      irq <= 1'b0;
    end else begin
      fault_q <= safety_circuit_fault;
      // A new event in the clearing cycle survives the clear
      status <= (status & ~clr) | ev;
      irq <= |(((status & ~clr) | ev) & mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      second_safety_monitor_out <= 1'b0;
    end else begin
      // Registered so it lines up with the terminals, which lag by one cycle
      second_safety_monitor_out <= !safety_circuit_fault;
    end
  end

  assign run_terminal_out = term_q[otfs_pkg::OTFS_TERM_RUN];
  assign relay_changeover_terminal = term_q[otfs_pkg::OTFS_TERM_RELAY];
  assign safety_terminal_out = term_q[otfs_pkg::OTFS_TERM_SAFETY];

  // ************************************************************
  // Read channel
  // ************************************************************
  logic [31:0] rd_mux;

  // Decoded from the live address, which the master holds until arready
  always_comb begin
    case (s_axi_araddr)
      ADDR_W'(`OTFS_OFF_RUN_SEL): rd_mux = {16'h0000, sel[0]};
      ADDR_W'(`OTFS_OFF_RELAY_SEL): rd_mux = {16'h0000, sel[1]};
      ADDR_W'(`OTFS_OFF_SAFETY_SEL): rd_mux = {16'h0000, sel[2]};
      ADDR_W'(`OTFS_OFF_REMOTE): rd_mux = {20'h00000, remote_word};
      ADDR_W'(`OTFS_OFF_EXT_DISP): rd_mux = {16'h0000, ext_disp};
      ADDR_W'(`OTFS_OFF_STATUS): rd_mux = {30'h0, status};
      ADDR_W'(`OTFS_OFF_MASK): rd_mux = {30'h0, mask};
      ADDR_W'(`OTFS_OFF_LEVELS): rd_mux = {28'h0000000, second_safety_monitor_out, term_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      end
    end
  end

endmodule : otfs_top

/* hw/otfs_map.svh */
`ifndef OTFS_MAP_SVH
`define OTFS_MAP_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OTFS_OFF_RUN_SEL 8'h00
`define OTFS_OFF_RELAY_SEL 8'h04
`define OTFS_OFF_SAFETY_SEL 8'h08
`define OTFS_OFF_REMOTE 8'h0c
`define OTFS_OFF_EXT_DISP 8'h10
`define OTFS_OFF_STATUS 8'h14
`define OTFS_OFF_MASK 8'h18
`define OTFS_OFF_LEVELS 8'h1c

// ************************************************************
// Reset values
// ************************************************************
`define OTFS_RST_RUN_SEL 16'h0000
`define OTFS_RST_RELAY_SEL 16'h0063
`define OTFS_RST_SAFETY_SEL 16'h0050
`define OTFS_RST_REMOTE 12'h000
`define OTFS_RST_EXT_DISP 16'h0000

// ************************************************************
// Function codes
// ************************************************************
`define OTFS_NEG_OFFSET 16'h0064
`define OTFS_CODE_NONE 16'h270f
`define OTFS_CODE_SECOND_SAFETY_MONITOR_OUT 7'h51
`define OTFS_CODE_REMOTE 7'h60
`define OTFS_CODE_RELAY_BAD 7'h5d

// ************************************************************
// Remote word bit positions
// ************************************************************
`define OTFS_REM_RUN 4'h0
`define OTFS_REM_RELAY 4'h5
`define OTFS_REM_SAFETY 4'h7

// ************************************************************
// Status bits
// ************************************************************
`define OTFS_ST_REFUSED 0
`define OTFS_ST_SAFE_FAULT 1

`endif

/* hw/otfs_pkg.sv */
package otfs_pkg;

  typedef logic [15:0] otfs_code_t;
  typedef logic [11:0] otfs_remote_t;
  typedef logic [1:0] otfs_status_t;

  typedef enum logic [1:0] {
    OTFS_TERM_RUN = 2'h0,
    OTFS_TERM_RELAY = 2'h1,
    OTFS_TERM_SAFETY = 2'h2
  } otfs_term_e;

endpackage : otfs_pkg

/* verif/otfs_props.sv */
module otfs_props #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic safety_circuit_fault,
  input wire logic second_safety_monitor_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ADDR_W-1:0] wa;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      wa <= s_axi_awaddr;
    end
  end
  // ****
  // Checks
  // ****
  a_second_safety_monitor_out_track: assert property ($past(aresetn) |->
    second_safety_monitor_out == !$past(safety_circuit_fault)) else $error("second_safety_monitor_out wrong");
  a_second_safety_monitor_out_fall: assert property ($rose(safety_circuit_fault) |=>
    !second_safety_monitor_out) else $error("second_safety_monitor_out not dropped");
  a_reset_quiet: assert property ($rose(aresetn) |->
    !s_axi_bvalid && !s_axi_rvalid && !second_safety_monitor_out) else $error("reset state");
  a_bresp_okay: assert property (s_axi_bvalid && wa[1:0] == 2'h0 && wa <= 8'h1c |->
    s_axi_bresp == 2'h0) else $error("mapped write not okay");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready stayed high");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_fault: cover property ($rose(safety_circuit_fault));
endmodule : otfs_props

bind otfs_top otfs_props #(.ADDR_W(ADDR_W)) otfs_props_inst (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .safety_circuit_fault,
  .second_safety_monitor_out);

/* verif/test_output_terminal_function_select.sv */
module test_output_terminal_function_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, safety_circuit_fault = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [99:0] function_signals = 100'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rv;
  logic run_terminal_out, relay_changeover_terminal, safety_terminal_out;
  logic second_safety_monitor_out;
  logic [3:0] term;
  int n_fail = 0, checks = 0, cyc = 0;
  assign term = {second_safety_monitor_out, safety_terminal_out, relay_changeover_terminal,
    run_terminal_out};
  always #25 aclk = ~aclk;
  otfs_top otfs_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .function_signals, .safety_circuit_fault, .run_terminal_out,
    .relay_changeover_terminal, .safety_terminal_out, .second_safety_monitor_out, .irq);
  // ****
  // Bus tasks
  // ****
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  // Ready raised once both valids drop, on the same edge bvalid rises, so a response is never held
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!s_axi_awvalid && !s_axi_wvalid) s_axi_bready <= 1'b1;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (!s_axi_arvalid) s_axi_rready <= 1'b1;
    end
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // ****
  // Tests
  // ****
  task automatic t_reset;
    logic [31:0] e[7] = '{32'h0, 32'h63, 32'h50, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4));
      chk("reset value", rv, e[i]);
    end
    $display("t_reset done");
  endtask : t_reset
  task automatic t_second_safety_monitor_out;
    function_signals <= 100'h1;
    for (int i = 0; i < 3; i++) begin
      wr(8'(i * 4), 32'h51);
      tick(2);
      chk("second_safety_monitor_out terminal", term[i], 1'b1);
      safety_circuit_fault <= 1'b1;
      tick(2);
      chk("terminal in fault", term[i], 1'b0);
      chk("second_safety_monitor_out in fault", second_safety_monitor_out, 1'b0);
      wr(8'(i * 4), 32'hb5);
      tick(2);
      chk("negated second_safety_monitor_out", term[i], 1'b1);
      safety_circuit_fault <= 1'b0;
    end
    wr(8'h00, 32'h0);
    tick(2);
    chk("code 0", run_terminal_out, 1'b1);
    wr(8'h00, 32'h64);
    tick(2);
    chk("code 100", run_terminal_out, 1'b0);
    $display("t_second_safety_monitor_out done");
  endtask : t_second_safety_monitor_out
  task automatic t_refuse;
    logic [7:0] a[8] = '{8'h04, 8'h04, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h08};
    logic [15:0] c[8] = '{16'h5d, 16'hc1, 16'h5d, 16'h270f, 16'h270f, 16'h2, 16'h69, 16'hc1};
    logic [7:0] ok = 8'h94;
    logic [31:0] old;
    for (int i = 0; i < 8; i++) begin
      rd(a[i]);
      old = rv;
      wr(a[i], {16'h0, c[i]});
      rd(a[i]);
      chk("selector", rv, ok[i] ? {16'h0, c[i]} : old);
    end
    wr(8'h10, 32'h1);
    rd(8'h00);
    old = rv;
    wr(8'h00, 32'h51);
    rd(8'h00);
    chk("locked selector", rv, old);
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h51);
    rd(8'h00);
    chk("unlocked selector", rv, 32'h51);
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_remote;
    logic [11:0] p[4] = '{12'h001, 12'h020, 12'h080, 12'hf5e};
    wr(8'h00, 32'h60);
    wr(8'h04, 32'h60);
    wr(8'h08, 32'hc4);
    for (int i = 0; i < 4; i++) begin
      wr(8'h0c, {20'h0, p[i]});
      tick(2);
      chk("remote terminals", term[2:0], {~p[i][7], p[i][5], p[i][0]});
      rd(8'h0c);
      chk("remote word", rv, {20'h0, p[i]});
    end
    $display("t_remote done");
  endtask : t_remote
  task automatic t_irq;
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h1);
    tick(2);
    chk("irq idle", irq, 1'b0);
    wr(8'h04, 32'd93);
    tick(2);
    chk("irq on refusal", irq, 1'b1);
    rd(8'h14);
    chk("status", rv[0], 1'b1);
    wr(8'h14, 32'h1);
    tick(2);
    chk("irq cleared", irq, 1'b0);
    wr(8'h18, 32'h2);
    safety_circuit_fault <= 1'b1;
    tick(3);
    chk("irq on fault", irq, 1'b1);
    safety_circuit_fault <= 1'b0;
    rd(8'h20);
    chk("unmapped read", rs, 2'h2);
    wr(8'h24, 32'h5);
    chk("unmapped write", rs, 2'h2);
    $display("t_irq done");
  endtask : t_irq
  // Selectors were all moved by now, so a second reset proves they return
  task automatic t_rst_again;
    logic [31:0] e[4] = '{32'h0, 32'h63, 32'h50, 32'h0};
    aresetn <= 1'b0;
    tick(6);
    chk("terminals in reset", term, 4'h0);
    chk("irq in reset", irq, 1'b0);
    aresetn <= 1'b1;
    tick(2);
    for (int i = 0; i < 4; i++) begin
      rd(8'(i * 4));
      chk("value after reset", rv, e[i]);
    end
    $display("t_rst_again done");
  endtask : t_rst_again
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    t_reset;
    t_second_safety_monitor_out;
    t_refuse;
    t_remote;
    t_irq;
    t_rst_again;
    report_and_stop;
  end
endmodule : test_output_terminal_function_select
